// *** tpp_pkg.sv ***
`default_nettype none
package tpp_pkg;

  localparam int unsigned TPP_CLK_MHZ = 100;

  // register byte offsets
  localparam logic [7:0] TPP_OFF_CTRL    = 8'h00;
  localparam logic [7:0] TPP_OFF_RELOAD  = 8'h04;
  localparam logic [7:0] TPP_OFF_COMPARE = 8'h08;
  localparam logic [7:0] TPP_OFF_COUNT   = 8'h0c;
  localparam logic [7:0] TPP_OFF_CAPTURE = 8'h10;
  localparam logic [7:0] TPP_OFF_STATUS  = 8'h14;

  // timer_control_zero field positions
  localparam int unsigned TPP_CTRL_EN_POS    = 0;
  localparam int unsigned TPP_CTRL_MODE_POS  = 1;
  localparam int unsigned TPP_CTRL_POL_POS   = 3;
  localparam int unsigned TPP_CTRL_DLY_POS   = 4;
  localparam int unsigned TPP_CTRL_PRESCALE_SELECT_POS  = 8;
  localparam int unsigned TPP_CTRL_ALT_POS   = 12;

  // status field positions
  localparam int unsigned TPP_STAT_RUN_POS   = 0;
  localparam int unsigned TPP_STAT_OUT_POS   = 1;
  localparam int unsigned TPP_STAT_OUTN_POS  = 2;
  localparam int unsigned TPP_STAT_CAPF_POS  = 3;

  localparam int unsigned TPP_DLY_W  = 3;
  localparam int unsigned TPP_PRESCALE_SELECT_W = 3;
  localparam int unsigned TPP_PCNT_W = 7;

  // reset values, and the count loaded at enable
  localparam logic [15:0] TPP_RELOAD_RST  = 16'hffff;
  localparam logic [15:0] TPP_COMPARE_RST = 16'h8000;
  localparam logic [15:0] TPP_COUNT_START = 16'h0001;

  typedef enum logic [1:0] {
    TPP_MODE_CAPCMP  = 2'b00,
    TPP_MODE_PWMDUAL = 2'b01,
    TPP_MODE_CAPRST  = 2'b10,
    TPP_MODE_CMPCNT  = 2'b11
  } tpp_mode_e;

  typedef struct packed {
    logic                  alt_sel;
    logic [TPP_PRESCALE_SELECT_W-1:0] prescale_select;
    logic [TPP_DLY_W-1:0]  pwm_transition_delay;
    logic                  output_polarity_bit;
    tpp_mode_e             mode;
    logic                  enable;
  } tpp_ctrl_s;

  localparam tpp_ctrl_s TPP_CTRL_RST = '{
    alt_sel:              1'b0,
    prescale_select:      3'h0,
    pwm_transition_delay: 3'h0,
    output_polarity_bit:  1'b0,
    mode:                 TPP_MODE_CAPCMP,
    enable:               1'b0
  };

endpackage
`default_nettype wire

// *** tpp_timer.sv ***
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module tpp_timer
  import tpp_pkg::*;
#(
  parameter int unsigned CNT_W = 16
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        timer_input,
  output var  logic        timer_output_pin,
  output var  logic        timer_output_pin_oe,
  output var  logic        timer_output_comp
);
  import tpp_pkg::*;

  // ---------------- register file over APB ----------------
  tpp_ctrl_s        ctrl_reg,    ctrl_next;
  logic [CNT_W-1:0] reload_reg,  reload_next;
  logic [CNT_W-1:0] compare_reg, compare_next;
  logic [31:0]      prdata_reg,  prdata_next;
  logic             pready_reg,  pready_next;
  logic             pslverr_reg, pslverr_next;

  logic [CNT_W-1:0] count_reg,   count_next;
  logic [CNT_W-1:0] capture_reg, capture_next;
  logic             capf_reg,    capf_next;
  logic             counting_reg, counting_next;
  logic             out_reg,     out_next;
  logic             outn_reg,    outn_next;
  logic             oe_reg,      oe_next;

  logic acc_done;
  logic wr_en;
  logic stat_clr;
  logic addr_ok;

  // one wait state: pready rises in the second access cycle
  assign acc_done = psel && penable && pready_reg;
  assign wr_en    = acc_done && pwrite;
  assign stat_clr = wr_en && (paddr == TPP_OFF_STATUS) &&
                    pwdata[TPP_STAT_CAPF_POS];

  always_comb
  begin
    addr_ok = 1'b0;
    if (paddr == TPP_OFF_CTRL)
      addr_ok = 1'b1;
    else if (paddr == TPP_OFF_RELOAD)
      addr_ok = 1'b1;
    else if (paddr == TPP_OFF_COMPARE)
      addr_ok = 1'b1;
    else if (paddr == TPP_OFF_COUNT)
      addr_ok = 1'b1;
    else if (paddr == TPP_OFF_CAPTURE)
      addr_ok = 1'b1;
    else if (paddr == TPP_OFF_STATUS)
      addr_ok = 1'b1;
  end

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    reload_next  = reload_reg;
    compare_next = compare_reg;
    prdata_next  = prdata_reg;
    pslverr_next = 1'b0;
    pready_next  = psel && penable && !pready_reg;
    if (psel && penable && !pready_reg)
    begin
      pslverr_next = !addr_ok;
      prdata_next  = 32'h0;
      if (!pwrite)
      begin
        if (paddr == TPP_OFF_CTRL)
          prdata_next = {19'h0, ctrl_reg.alt_sel, 1'b0,
                         ctrl_reg.prescale_select, 1'b0,
                         ctrl_reg.pwm_transition_delay,
                         ctrl_reg.output_polarity_bit,
                         ctrl_reg.mode, ctrl_reg.enable};
        else if (paddr == TPP_OFF_RELOAD)
          prdata_next[CNT_W-1:0] = reload_reg;
        else if (paddr == TPP_OFF_COMPARE)
          prdata_next[CNT_W-1:0] = compare_reg;
        else if (paddr == TPP_OFF_COUNT)
          prdata_next[CNT_W-1:0] = count_reg;
        else if (paddr == TPP_OFF_CAPTURE)
          prdata_next[CNT_W-1:0] = capture_reg;
        else if (paddr == TPP_OFF_STATUS)
        begin
          prdata_next[TPP_STAT_RUN_POS]  = counting_reg;
          prdata_next[TPP_STAT_OUT_POS]  = out_reg;
          prdata_next[TPP_STAT_OUTN_POS] = outn_reg;
          prdata_next[TPP_STAT_CAPF_POS] = capf_reg;
        end
      end
    end
    if (wr_en)
    begin
      if (paddr == TPP_OFF_CTRL)
      begin
        ctrl_next.enable  = pwdata[TPP_CTRL_EN_POS];
        ctrl_next.mode    = tpp_mode_e'(pwdata[TPP_CTRL_MODE_POS +: 2]);
        ctrl_next.output_polarity_bit = pwdata[TPP_CTRL_POL_POS];
        ctrl_next.pwm_transition_delay =
          pwdata[TPP_CTRL_DLY_POS +: TPP_DLY_W];
        ctrl_next.prescale_select = pwdata[TPP_CTRL_PRESCALE_SELECT_POS +: TPP_PRESCALE_SELECT_W];
        ctrl_next.alt_sel = pwdata[TPP_CTRL_ALT_POS];
      end
      else if (paddr == TPP_OFF_RELOAD)
        reload_next = pwdata[CNT_W-1:0];
      else if (paddr == TPP_OFF_COMPARE)
        compare_next = pwdata[CNT_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg    <= TPP_CTRL_RST;
      reload_reg  <= TPP_RELOAD_RST[CNT_W-1:0];
      compare_reg <= TPP_COMPARE_RST[CNT_W-1:0];
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      reload_reg  <= reload_next;
      compare_reg <= compare_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ---------------- prescaler ----------------
  logic [TPP_PCNT_W-1:0] prescale_select_reg, prescale_select_next;
  logic [TPP_PCNT_W:0]   prescale_select_full;
  logic [TPP_PCNT_W-1:0] prescale_select_mask;
  logic                  tick;

  assign prescale_select_full = {{TPP_PCNT_W{1'b0}}, 1'b1} << ctrl_reg.prescale_select;
  assign prescale_select_mask = TPP_PCNT_W'(prescale_select_full - 8'h01);
  // tick marks the last cycle of each 2^prescale window
  assign tick = ctrl_reg.enable && ((prescale_select_reg & prescale_select_mask) == prescale_select_mask);

  always_comb
  begin
    prescale_select_next = TPP_PCNT_W'(prescale_select_reg + 7'h01);
    if (!ctrl_reg.enable)
      prescale_select_next = '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prescale_select_reg <= '0;
    else
      prescale_select_reg <= prescale_select_next;
  end

  // ---------------- timer core ----------------
  logic                 en_d_reg,   en_d_next;
  logic                 pol_run_reg, pol_run_next;
  logic                 in_d_reg,   in_d_next;
  logic                 pend_p_reg, pend_p_next;
  logic                 pend_n_reg, pend_n_next;
  logic [TPP_DLY_W-1:0] dly_reg,    dly_next;

  logic start;
  logic act_edge;
  logic inc;
  logic reload_ev;
  logic match_ev;
  logic is_pwm;

  assign start  = ctrl_reg.enable && !en_d_reg;
  assign is_pwm = (ctrl_reg.mode == TPP_MODE_PWMDUAL);
  // input edge of the polarity latched at enable
  assign act_edge = ctrl_reg.enable && (pol_run_reg ?
                    (in_d_reg && !timer_input) :
                    (!in_d_reg && timer_input));
  assign inc = ctrl_reg.enable && !start && counting_reg &&
               ((ctrl_reg.mode == TPP_MODE_CMPCNT) ? act_edge : tick);
  assign reload_ev = inc && (count_reg >= reload_reg);
  assign match_ev  = inc && (count_reg == compare_reg);

  always_comb
  begin
    en_d_next     = ctrl_reg.enable;
    in_d_next     = timer_input;
    pol_run_next  = pol_run_reg;
    count_next    = count_reg;
    capture_next  = capture_reg;
    counting_next = counting_reg;
    capf_next     = capf_reg && !stat_clr;
    out_next      = out_reg;
    outn_next     = outn_reg;
    pend_p_next   = pend_p_reg;
    pend_n_next   = pend_n_reg;
    dly_next      = dly_reg;
    oe_next       = ctrl_reg.alt_sel;
    if (!ctrl_reg.enable)
    begin
      // disabled pin follows the live polarity bit
      out_next      = ctrl_reg.output_polarity_bit;
      outn_next     = !ctrl_reg.output_polarity_bit;
      counting_next = 1'b0;
      pend_p_next   = 1'b0;
      pend_n_next   = 1'b0;
    end
    else if (start)
    begin
      // polarity frozen here so later writes wait for a restart
      pol_run_next  = ctrl_reg.output_polarity_bit;
      count_next    = TPP_COUNT_START[CNT_W-1:0];
      counting_next = (ctrl_reg.mode != TPP_MODE_CAPCMP);
    end
    else
    begin
      if (inc)
        count_next = reload_ev ? TPP_COUNT_START[CNT_W-1:0] :
                     CNT_W'(count_reg + 1'b1);
      if (ctrl_reg.mode == TPP_MODE_CAPCMP && act_edge)
      begin
        if (!counting_reg)
          counting_next = 1'b1;
        else
        begin
          capture_next = count_reg;
          capf_next    = 1'b1;
        end
      end
      if (ctrl_reg.mode == TPP_MODE_CAPRST && act_edge)
      begin
        capture_next = count_reg;
        capf_next    = 1'b1;
        count_next   = TPP_COUNT_START[CNT_W-1:0];
      end
      if (is_pwm)
      begin
        // pending active levels count down in prescaled ticks
        // applying only on a tick makes a delay of d last d whole ticks
        if (pend_p_reg && tick && dly_reg == '0)
        begin
          out_next    = !pol_run_reg;
          pend_p_next = 1'b0;
        end
        else if (pend_n_reg && tick && dly_reg == '0)
        begin
          outn_next   = !pol_run_reg;
          pend_n_next = 1'b0;
        end
        else if ((pend_p_reg || pend_n_reg) && tick)
          dly_next = TPP_DLY_W'(dly_reg - 1'b1);
        if (match_ev)
        begin
          outn_next   = pol_run_reg;
          pend_n_next = 1'b0;
          if (ctrl_reg.pwm_transition_delay == '0)
          begin
            out_next    = !pol_run_reg;
            pend_p_next = 1'b0;
          end
          else
          begin
            pend_p_next = 1'b1;
            dly_next    = TPP_DLY_W'(ctrl_reg.pwm_transition_delay - 1'b1);
          end
        end
        else if (reload_ev)
        begin
          out_next    = pol_run_reg;
          pend_p_next = 1'b0;
          if (ctrl_reg.pwm_transition_delay == '0)
          begin
            outn_next   = !pol_run_reg;
            pend_n_next = 1'b0;
          end
          else
          begin
            pend_n_next = 1'b1;
            dly_next    = TPP_DLY_W'(ctrl_reg.pwm_transition_delay - 1'b1);
          end
        end
      end
      else if (reload_ev)
      begin
        out_next  = !out_reg;
        outn_next = out_reg;
      end
    end
    // a capture in the clearing cycle still leaves the flag set
    if (ctrl_reg.enable && !start && act_edge && counting_reg &&
        (ctrl_reg.mode == TPP_MODE_CAPCMP || ctrl_reg.mode == TPP_MODE_CAPRST))
      capf_next = 1'b1;
    else if (ctrl_reg.enable && !start && act_edge &&
             ctrl_reg.mode == TPP_MODE_CAPRST)
      capf_next = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_d_reg     <= 1'b0;
      in_d_reg     <= 1'b0;
      pol_run_reg  <= 1'b0;
      count_reg    <= '0;
      capture_reg  <= '0;
      counting_reg <= 1'b0;
      capf_reg     <= 1'b0;
      out_reg      <= 1'b0;
      outn_reg     <= 1'b1;
      oe_reg       <= 1'b0;
      pend_p_reg   <= 1'b0;
      pend_n_reg   <= 1'b0;
      dly_reg      <= '0;
    end
    else
    begin
      en_d_reg     <= en_d_next;
      in_d_reg     <= in_d_next;
      pol_run_reg  <= pol_run_next;
      count_reg    <= count_next;
      capture_reg  <= capture_next;
      counting_reg <= counting_next;
      capf_reg     <= capf_next;
      out_reg      <= out_next;
      outn_reg     <= outn_next;
      oe_reg       <= oe_next;
      pend_p_reg   <= pend_p_next;
      pend_n_reg   <= pend_n_next;
      dly_reg      <= dly_next;
    end
  end

  assign timer_output_pin    = out_reg;
  assign timer_output_comp   = outn_reg;
  assign timer_output_pin_oe = oe_reg;

endmodule
`default_nettype wire

// *** tpp_timer_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpp_timer_properties
  import tpp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_output_pin,
  input wire logic        timer_output_pin_oe,
  input wire logic        timer_output_comp
);
  logic [12:0] ctrl_reg;
  logic [12:0] ctrl_next;
  logic        pol_reg;
  logic        pol_next;
  logic        wr_ctrl;
  logic        pwm_dly;
  assign wr_ctrl = pready && pwrite && paddr == TPP_OFF_CTRL;
  assign pwm_dly = ctrl_reg[0] && ctrl_reg[2:1] == 2'b01 && ctrl_reg[6:4] != 0;
  // polarity is latched by the timer only when it starts
  always_comb
  begin
    ctrl_next = wr_ctrl ? pwdata[12:0] : ctrl_reg;
    pol_next  = (wr_ctrl && pwdata[0] && !ctrl_reg[0]) ? pwdata[3] : pol_reg;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= 13'h0000;
      pol_reg  <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      pol_reg  <= pol_next;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_rdy_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready long");
  property p_err;
    pready && paddr > TPP_OFF_STATUS |-> pslverr;
  endproperty
  a_err: assert property (p_err) else $error("no pslverr");
  property p_idle;
    !ctrl_reg[0] && $stable(ctrl_reg) |->
      timer_output_pin == ctrl_reg[3] && timer_output_comp != ctrl_reg[3];
  endproperty
  a_idle: assert property (p_idle) else $error("idle level");
  property p_oe;
    $stable(ctrl_reg) |-> timer_output_pin_oe == ctrl_reg[12];
  endproperty
  a_oe: assert property (p_oe) else $error("oe level");
  property p_inv;
    ctrl_reg[0] && ctrl_reg[6:4] == 0 && $stable(ctrl_reg) |->
      timer_output_comp != timer_output_pin;
  endproperty
  a_inv: assert property (p_inv) else $error("comp not inverse");
  property p_dead;
    pwm_dly && $stable(ctrl_reg) |->
      timer_output_pin == pol_reg || timer_output_comp == pol_reg;
  endproperty
  a_dead: assert property (p_dead) else $error("no dead time");
  property p_pol_hold;
    wr_ctrl && ctrl_reg[0] && pwdata[0] && pwdata[3] != ctrl_reg[3] |->
      ##2 $stable(timer_output_pin);
  endproperty
  a_pol_hold: assert property (p_pol_hold) else $error("pin jumped");
  c_pwm: cover property (pwm_dly ##1 $changed(timer_output_comp));
  c_err: cover property (pready && pslverr);
  c_flip: cover property (wr_ctrl && ctrl_reg[0] && pwdata[0]);
endmodule
bind tpp_timer tpp_timer_properties i_tpp_timer_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe),
  .timer_output_comp(timer_output_comp)
);
`default_nettype wire

// *** tpp_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tpp_src_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [15:0] period,
  output var  logic        timer_input
);
  logic [15:0] cnt_reg;
  // held low while stopped, so the first edge of a burst is a rising one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg     <= 16'h0000;
      timer_input <= 1'b0;
    end
    else
    begin
      cnt_reg     <= (!run || cnt_reg == period - 16'h1) ? 16'h0 :
                     cnt_reg + 16'h1;
      timer_input <= run && cnt_reg < (period >> 1);
    end
  end
endmodule
`default_nettype wire

// *** tb_tpp_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_tpp_timer;
  import tpp_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tin;
  logic        pin;
  logic        oe;
  logic        comp;
  logic        run;
  logic [15:0] per;
  logic [31:0] rnd;
  logic [31:0] rq;
  logic [15:0] c1;
  logic [15:0] c2;
  logic        pol;
  logic [2:0]  d;
  int          num_errors;
  int          check_count;
  int          n;
  int          k;
  int          j;
  tpp_timer i_tpp_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input(tin),
    .timer_output_pin(pin), .timer_output_pin_oe(oe),
    .timer_output_comp(comp)
  );
  tpp_src_model i_tpp_src_model (
    .pclk(pclk), .presetn(presetn), .run(run), .period(per),
    .timer_input(tin)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic en, input logic [1:0] m,
    input logic pl, input logic [2:0] dl, input logic [2:0] ps);
    return {20'h0, 1'b0, ps, 1'b0, dl, pl, m, en} | 32'(m == 2'b11) << 12;
  endfunction
  // edges are a whole number of prescale steps apart, so the gap is exact
  function automatic logic [31:0] gap(input logic [15:0] pr, input int ps);
    return 32'(pr >> ps);
  endfunction
  // a restart loads the start value, so each capture spans one period
  function automatic logic [31:0] rst_cap(input logic [15:0] pr);
    return 32'(pr) + 32'(TPP_COUNT_START) - 32'h1;
  endfunction
  function automatic logic [31:0] dly(input logic [2:0] dl, input int ps);
    return 32'(dl) << ps;
  endfunction
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    chk("pready", 32'(pready), 32'h1);
    rq = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cap(output logic [15:0] c);
    int t;
    apb(1'b1, TPP_OFF_STATUS, 32'h8);
    t = 0;
    do
    begin
      apb(1'b0, TPP_OFF_STATUS, 32'h0);
      t++;
    end
    while (rq[TPP_STAT_CAPF_POS] !== 1'b1 && t < 500);
    chk("capf", 32'(rq[TPP_STAT_CAPF_POS]), 32'h1);
    apb(1'b0, TPP_OFF_CAPTURE, 32'h0);
    c = rq[15:0];
  endtask
  task automatic wait_o(input logic c, input logic lvl);
    #1;
    n = 0;
    while (((c ? comp : pin) !== lvl) && n < 3000)
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("wait", 32'(n < 3000), 32'h1);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #800000;
    num_errors++;
    end_of_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
    per = 16'h0080;
    rnd = 32'h00017668;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rq, 32'h0);
    apb(1'b1, TPP_OFF_RELOAD, 32'hffff);
    for (k = 0; k < 10; k++)
    begin
      rnd = lfsr(rnd);
      per = 16'h0080 * (16'h1 + 16'(rnd % 3));
      pol = rnd[5];
      apb(1'b1, TPP_OFF_STATUS, 32'h8);
      apb(1'b1, TPP_OFF_CTRL, k < 8 ? ctl(1'b1, 2'b00, pol, 3'h0, 3'(k))
                                    : ctl(1'b1, 2'b10, pol, 3'h0, 3'h0));
      @(posedge pclk);
      run <= 1'b1;
      repeat (20) @(posedge pclk);
      apb(1'b0, TPP_OFF_STATUS, 32'h0);
      chk("first", 32'(rq[k < 8 ? 0 : 3]), 32'(!pol));
      cap(c1);
      cap(c1);
      cap(c2);
      if (k < 8)
        chk("gap", 32'(c2 - c1), gap(per, k));
      else
      begin
        chk("restart", 32'(c1), rst_cap(per));
        chk("restart", 32'(c2), rst_cap(per));
      end
      apb(1'b1, TPP_OFF_CTRL, 32'h0);
      run <= 1'b0;
    end
    apb(1'b1, TPP_OFF_RELOAD, 32'h50);
    apb(1'b1, TPP_OFF_COMPARE, 32'h28);
    for (k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      pol = k[0];
      d = k < 2 ? 3'h0 : 3'h1 + 3'(rnd % 7);
      // the delayed passes also run prescaled, so delays are whole ticks
      apb(1'b1, TPP_OFF_CTRL, ctl(1'b0, 2'b01, pol, d, 3'(k >> 1)));
      wait_o(1'b0, pol);
      chk("off", 32'({pin, comp}), 32'({pol, !pol}));
      // second pass flips polarity mid-run: the old one must still rule
      for (j = 0; j < 2; j++)
      begin
        apb(1'b1, TPP_OFF_CTRL, ctl(1'b1, 2'b01, pol ^ j[0], d, 3'(k >> 1)));
        wait_o(1'b1, pol);
        wait_o(1'b0, !pol);
        chk("match", n, dly(d, k >> 1));
        wait_o(1'b0, pol);
        wait_o(1'b1, !pol);
        chk("reload", n, dly(d, k >> 1));
      end
      apb(1'b1, TPP_OFF_CTRL, 32'h0);
    end
    pol = rnd[3];
    per = 16'h0014;
    apb(1'b1, TPP_OFF_RELOAD, 32'h3);
    apb(1'b1, TPP_OFF_CTRL, ctl(1'b0, 2'b11, pol, 3'h0, 3'h0));
    repeat (2) @(posedge pclk);
    #1;
    chk("alt", 32'({oe, pin}), 32'({1'b1, pol}));
    apb(1'b1, TPP_OFF_CTRL, ctl(1'b1, 2'b11, pol, 3'h0, 3'h0));
    repeat (100) @(posedge pclk);
    #1;
    chk("still", 32'(pin), 32'(pol));
    @(posedge pclk);
    run <= 1'b1;
    for (j = 0; j < 2; j++)
    begin
      wait_o(1'b0, pol ^ !j[0]);
      chk("toggle", 32'(n < 3000), 32'h1);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
